// file: rtl/txll_line_tx.sv
// module: one ds-1 line's transmit pins, data-link clocking and apb registers
//
// Notes on behaviour
// R1 - data-link clock runs only with hdlc engine off or fractional insertion on.
// R2 - link data sampled at each data-link clock rising edge; source presents it.
// R3 - superframe format without fractional insertion keeps data-link clock low.
// R4 - hdlc engine on: underrun rises if buffer empties with request unserviced.
// R5 - a line clock output at the ds-1 rate is provided per line.
// R6 - line clock source: line input, recovered or backplane clock, attenuated or not.
// R7 - pulse and single-rail outputs update on configured edge of line clock.
// R8 - dual-rail mode drives positive pulse output, return-to-zero or not.
// R9 - single-rail mode drives serial data on pin shared with positive pulse.
// R10 - dual-rail mode drives negative pulse output, formatted like positive one.
// R11 - data-link interrupt rises when last byte is loaded and more is needed.
// R12 - external source supplies data-link, framing, r-bit or fractional data.
// R13 - one instance per line, configured alone, nothing shared between instances.
`timescale 1ns/100ps
module txll_line_tx (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // clock pins from outside
  input  wire logic        line_clk_in,
  input  wire logic        recovered_rx_clk,
  input  wire logic        backplane_tx_clk,
  // data-link pins
  input  wire logic        tx_link_data_in,
  output logic             tx_link_clk_out,
  output logic             tx_link_underrun,
  output logic             tx_link_irq,
  // hdlc engine and framer side, same clock
  input  wire logic        hdlcLastByteSetup,
  input  wire logic        hdlcBufEmpty,
  input  wire logic        linkSlot,
  input  wire logic        framerPos,
  input  wire logic        framerNeg,
  input  wire logic        framerSerial,
  output logic             linkBit,
  output logic             linkBitValid,
  output logic             lineBitReq,
  // line pins
  output logic             line_clk_out,
  output logic             pos_pulse_out,
  output logic             neg_pulse_out,
  output logic             single_rail_out
);

  // ---------------------------------------------------------------
  // line clock generation
  // ---------------------------------------------------------------
  // each instance owns its generator and registers; nothing is shared  (see R13)
  txll_clk_if clkIf ();

  txll_clk_gen uClkGen (
    .ref_clk          (ref_clk),
    .reset            (reset),
    .line_clk_in      (line_clk_in),
    .recovered_rx_clk (recovered_rx_clk),
    .backplane_tx_clk (backplane_tx_clk),
    .clkIf            (clkIf.gen)
  );

  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  logic [txll_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [txll_pkg::STAT_W-1:0] stat_reg, stat_next, mask_reg, mask_next, statSet;
  logic [31:0]                 prdata_reg, prdata_next;
  logic                        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic                        irq_reg, irq_next;
  logic                        setupPh, wrTake, mapped;
  logic                        hdlcEn, fracEn, linkClkEn, bufEmptySeen;

  assign hdlcEn = ctrl_reg[txll_pkg::CB_HDLC_EN];
  assign fracEn = ctrl_reg[txll_pkg::CB_FRAC_EN];
  // data-link clock allowed with engine off or fractional on, never sf without fractional  (see R1) (see R3)
  assign linkClkEn = (!hdlcEn || fracEn) && !(ctrl_reg[txll_pkg::CB_SF_FMT] && !fracEn);

  assign clkIf.srcSel      = ctrl_reg[txll_pkg::CB_SRC_LO +: 2];  // see R6
  assign clkIf.jitterAtten = ctrl_reg[txll_pkg::CB_JIT_ATTEN];    // see R6

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == txll_pkg::OFS_CTRL) || (a == txll_pkg::OFS_STATUS) ||
               (a == txll_pkg::OFS_MASK) || (a == txll_pkg::OFS_STATE);
  endfunction

  always_comb begin
    setupPh = psel && !penable;
    mapped  = isMapped(paddr);
    // the answer is prepared in setup so the access phase always completes at once
    wrTake  = psel && penable && pwrite && pready_reg;
    pready_next  = setupPh;
    pslverr_next = setupPh && !mapped;
    prdata_next  = prdata_reg;
    if (setupPh) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        txll_pkg::OFS_CTRL:   prdata_next[txll_pkg::CTRL_W-1:0] = ctrl_reg;
        txll_pkg::OFS_STATUS: prdata_next[txll_pkg::STAT_W-1:0] = stat_reg;
        txll_pkg::OFS_MASK:   prdata_next[txll_pkg::STAT_W-1:0] = mask_reg;
        txll_pkg::OFS_STATE: begin
          prdata_next[txll_pkg::STB_BUF_EMPTY] = hdlcBufEmpty;
          prdata_next[txll_pkg::STB_LINE_CLK]  = clkIf.clkLevel;
          prdata_next[txll_pkg::STB_LINK_EN]   = linkClkEn;
        end
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (wrTake && paddr == txll_pkg::OFS_CTRL) begin
      ctrl_next = pwdata[txll_pkg::CTRL_W-1:0];
    end
    if (wrTake && paddr == txll_pkg::OFS_MASK) begin
      mask_next = pwdata[txll_pkg::STAT_W-1:0];
    end
    // interrupt events: request on last byte loaded, underrun on empty with request pending
    bufEmptySeen = hdlcEn && hdlcBufEmpty && stat_reg[txll_pkg::SB_TX_REQ];         // see R4
    statSet = '0;
    statSet[txll_pkg::SB_TX_REQ]   = hdlcEn && hdlcLastByteSetup;                   // see R11
    statSet[txll_pkg::SB_UNDERRUN] = bufEmptySeen;                                  // see R4
    stat_next = stat_reg;
    if (wrTake && paddr == txll_pkg::OFS_STATUS) begin
      stat_next = stat_reg & ~pwdata[txll_pkg::STAT_W-1:0];
    end
    // a set in the clearing cycle wins
    stat_next = stat_next | statSet;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg    <= txll_pkg::CTRL_RST;
      stat_reg    <= txll_pkg::STAT_RST;
      mask_reg    <= txll_pkg::MASK_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // data-link pins
  // ---------------------------------------------------------------
  localparam int unsigned HW = $clog2(txll_pkg::LINK_CLK_HIGH_CYC + 1);
  logic          dSyncA_reg, dSyncB_reg;
  logic          dlClk_reg, dlClk_next, dlBit_reg, dlBit_next, dlVal_reg, dlVal_next;
  logic          udr_reg, udr_next, tlIrq_reg, tlIrq_next;
  logic [HW-1:0] dlCnt_reg, dlCnt_next;

  always_comb begin
    dlClk_next = dlClk_reg;
    dlCnt_next = dlCnt_reg;
    dlBit_next = dlBit_reg;
    dlVal_next = 1'b0;
    if (!linkClkEn) begin
      // output held low whenever the pin is not in use  (see R1) (see R3)
      dlClk_next = 1'b0;
      dlCnt_next = '0;
    end else if (linkSlot && !dlClk_reg) begin
      // data sampled at the very edge we raise; source set it up after the fall  (see R2) (see R12)
      dlClk_next = 1'b1;
      dlCnt_next = HW'(txll_pkg::LINK_CLK_HIGH_CYC - 1);
      dlBit_next = dSyncB_reg;
      dlVal_next = 1'b1;
    end else if (dlClk_reg) begin
      if (dlCnt_reg == '0) begin
        dlClk_next = 1'b0;
      end else begin
        dlCnt_next = dlCnt_reg - HW'(1);
      end
    end
    // pin outputs only meaningful while the hdlc engine is enabled
    udr_next   = hdlcEn && stat_next[txll_pkg::SB_UNDERRUN];  // see R4
    tlIrq_next = hdlcEn && stat_next[txll_pkg::SB_TX_REQ];    // see R11
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dSyncA_reg <= 1'b1;
      dSyncB_reg <= 1'b1;
      dlClk_reg  <= 1'b0;
      dlCnt_reg  <= '0;
      dlBit_reg  <= 1'b0;
      dlVal_reg  <= 1'b0;
      udr_reg    <= 1'b0;
      tlIrq_reg  <= 1'b0;
    end else begin
      dSyncA_reg <= tx_link_data_in;
      dSyncB_reg <= dSyncA_reg;
      dlClk_reg  <= dlClk_next;
      dlCnt_reg  <= dlCnt_next;
      dlBit_reg  <= dlBit_next;
      dlVal_reg  <= dlVal_next;
      udr_reg    <= udr_next;
      tlIrq_reg  <= tlIrq_next;
    end
  end

  // ---------------------------------------------------------------
  // line data pins
  // ---------------------------------------------------------------
  logic pos_reg, pos_next, neg_reg, neg_next, ser_reg, ser_next, req_reg, req_next;
  logic updEdge, otherEdge, dualRail, rzMode;

  always_comb begin
    dualRail  = ctrl_reg[txll_pkg::CB_DUAL_RAIL];
    rzMode    = !ctrl_reg[txll_pkg::CB_NRZ];
    updEdge   = ctrl_reg[txll_pkg::CB_FALL_EDGE] ? clkIf.fallEv : clkIf.riseEv;  // see R7
    otherEdge = ctrl_reg[txll_pkg::CB_FALL_EDGE] ? clkIf.riseEv : clkIf.fallEv;
    pos_next  = pos_reg;
    neg_next  = neg_reg;
    ser_next  = ser_reg;
    req_next  = updEdge;
    if (updEdge) begin
      if (dualRail) begin
        pos_next = framerPos;      // see R8
        neg_next = framerNeg;      // see R10
        ser_next = 1'b0;
      end else begin
        // shared pin carries the serial stream; negative rail idles low  (see R9)
        pos_next = framerSerial;
        neg_next = 1'b0;
        ser_next = framerSerial;
      end
    end else if (otherEdge && dualRail && rzMode) begin
      // return-to-zero: pulses last half a bit  (see R8) (see R10)
      pos_next = 1'b0;
      neg_next = 1'b0;
      ser_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
      ser_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      ser_reg <= ser_next;
      req_reg <= req_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign irq              = irq_reg;
  assign tx_link_clk_out  = dlClk_reg;
  assign tx_link_underrun = udr_reg;
  assign tx_link_irq      = tlIrq_reg;
  assign linkBit          = dlBit_reg;
  assign linkBitValid     = dlVal_reg;
  assign lineBitReq       = req_reg;
  assign line_clk_out     = clkIf.clkLevel;  // see R5
  assign pos_pulse_out    = pos_reg;
  assign neg_pulse_out    = neg_reg;
  assign single_rail_out  = ser_reg;

endmodule // txll_line_tx

// file: common/txll_pkg.sv
// package: constants for the ds-1 transmit line and data-link pin block
package txll_pkg;

  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ         = 100_000_000;
  localparam int unsigned LINK_CLK_HIGH_NS   = 320;
  localparam int unsigned LINK_CLK_HIGH_CYC  = (LINK_CLK_HIGH_NS * (REF_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned LINE_IN_DIVIDE     = 8;
  localparam int unsigned PERIOD_W           = 10;
  localparam int unsigned AVG_FRAC_W         = 4;
  localparam int unsigned AVG_SHIFT          = 4;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 10'h3FF;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 10'h041;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W        = 9;
  localparam int unsigned CB_HDLC_EN    = 0;
  localparam int unsigned CB_FRAC_EN    = 1;
  localparam int unsigned CB_SF_FMT     = 2;
  localparam int unsigned CB_DUAL_RAIL  = 3;
  localparam int unsigned CB_NRZ        = 4;
  localparam int unsigned CB_FALL_EDGE  = 5;
  localparam int unsigned CB_SRC_LO     = 6;
  localparam int unsigned CB_JIT_ATTEN  = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h008;

  // ---------------------------------------------------------------
  // status, mask and state fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_W      = 2;
  localparam int unsigned SB_TX_REQ   = 0;
  localparam int unsigned SB_UNDERRUN = 1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
  localparam int unsigned STB_BUF_EMPTY = 0;
  localparam int unsigned STB_LINE_CLK  = 1;
  localparam int unsigned STB_LINK_EN   = 2;

  // line clock source choice
  typedef enum logic [1:0] {
    TXLL_SRC_LINE_IN   = 2'h0,
    TXLL_SRC_RECOVERED = 2'h1,
    TXLL_SRC_BACKPLANE = 2'h2
  } txll_src_e;

endpackage

// file: common/txll_clk_if.sv
// interface: line clock generator controls and edge events
`timescale 1ns/100ps
interface txll_clk_if;
  logic [1:0] srcSel;
  logic       jitterAtten;
  logic       riseEv;
  logic       fallEv;
  logic       clkLevel;

  modport gen (
    input  srcSel,
    input  jitterAtten,
    output riseEv,
    output fallEv,
    output clkLevel
  );

  modport user (
    output srcSel,
    output jitterAtten,
    input  riseEv,
    input  fallEv,
    input  clkLevel
  );
endinterface // txll_clk_if

// file: rtl/txll_clk_gen.sv
// module: transmit line clock generation from a chosen source clock
`timescale 1ns/100ps
module txll_clk_gen (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic line_clk_in,
  input  wire logic recovered_rx_clk,
  input  wire logic backplane_tx_clk,
  txll_clk_if.gen   clkIf
);

  // ---------------------------------------------------------------
  // source synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] syncA_reg, syncB_reg, syncC_reg;
  logic [2:0] syncA_next, syncB_next, syncC_next;
  logic [2:0] divCnt_reg, divCnt_next;
  logic [2:0] srcRise;
  logic       srcTick;

  always_comb begin
    syncA_next = {backplane_tx_clk, recovered_rx_clk, line_clk_in};
    syncB_next = syncA_reg;
    syncC_next = syncB_reg;
    srcRise    = syncB_reg & ~syncC_reg;
    divCnt_next = divCnt_reg;
    if (srcRise[0]) begin
      divCnt_next = divCnt_reg + 3'h1;
    end
    unique case (clkIf.srcSel)
      txll_pkg::TXLL_SRC_RECOVERED: srcTick = srcRise[1];
      txll_pkg::TXLL_SRC_BACKPLANE: srcTick = srcRise[2];
      // line input runs at eight times the line rate
      default:                      srcTick = srcRise[0] && (divCnt_reg == 3'(txll_pkg::LINE_IN_DIVIDE - 1));
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncA_reg  <= 3'h0;
      syncB_reg  <= 3'h0;
      syncC_reg  <= 3'h0;
      divCnt_reg <= 3'h0;
    end else begin
      syncA_reg  <= syncA_next;
      syncB_reg  <= syncB_next;
      syncC_reg  <= syncC_next;
      divCnt_reg <= divCnt_next;
    end
  end

  // ---------------------------------------------------------------
  // period measurement, smoothing and output clock
  // ---------------------------------------------------------------
  localparam int unsigned AW = txll_pkg::PERIOD_W + txll_pkg::AVG_FRAC_W;
  logic [txll_pkg::PERIOD_W-1:0] measCnt_reg, measCnt_next, meas_reg, meas_next;
  logic [txll_pkg::PERIOD_W-1:0] outCnt_reg, outCnt_next, avgInt, halfPer;
  logic [AW-1:0]                 avg_reg, avg_next;
  logic                          rise_reg, rise_next, fall_reg, fall_next, lvl_reg, lvl_next, riseNow;

  always_comb begin
    measCnt_next = (measCnt_reg == txll_pkg::PERIOD_MAX) ? measCnt_reg : measCnt_reg + 10'h001;
    meas_next    = meas_reg;
    avg_next     = avg_reg;
    if (srcTick) begin
      measCnt_next = 10'h001;
      meas_next    = measCnt_reg;
      // slow first-order filter: source jitter is spread over many periods
      avg_next = AW'(avg_reg + AW'($signed({1'b0, measCnt_reg, {txll_pkg::AVG_FRAC_W{1'b0}}} -
                 {1'b0, avg_reg}) >>> txll_pkg::AVG_SHIFT));
    end
    avgInt  = avg_reg[AW-1:txll_pkg::AVG_FRAC_W];
    riseNow = clkIf.jitterAtten ? (outCnt_reg + 10'h001 >= avgInt) : srcTick;
    halfPer = (clkIf.jitterAtten ? avgInt : meas_reg) >> 1;
    outCnt_next = riseNow ? 10'h000 : outCnt_reg + 10'h001;
    // events only where the level really moves, so a source switch cannot double an edge
    rise_next   = riseNow && !lvl_reg;
    fall_next   = !riseNow && lvl_reg && (outCnt_reg == halfPer);
    lvl_next    = riseNow ? 1'b1 : (fall_next ? 1'b0 : lvl_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      measCnt_reg <= 10'h000;
      meas_reg    <= txll_pkg::PERIOD_RST;
      avg_reg     <= {txll_pkg::PERIOD_RST, {txll_pkg::AVG_FRAC_W{1'b0}}};
      outCnt_reg  <= 10'h000;
      rise_reg    <= 1'b0;
      fall_reg    <= 1'b0;
      lvl_reg     <= 1'b0;
    end else begin
      measCnt_reg <= measCnt_next;
      meas_reg    <= meas_next;
      avg_reg     <= avg_next;
      outCnt_reg  <= outCnt_next;
      rise_reg    <= rise_next;
      fall_reg    <= fall_next;
      lvl_reg     <= lvl_next;
    end
  end

  assign clkIf.riseEv   = rise_reg;
  assign clkIf.fallEv   = fall_reg;
  assign clkIf.clkLevel = lvl_reg;

endmodule // txll_clk_gen

// file: tb/txll_line_tx_properties.sv
// checker: concurrent properties on the transmit line block's ports
`timescale 1ns/100ps
module txll_tx_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic linkSlot,
  input wire logic tx_link_clk_out,
  input wire logic linkBitValid,
  input wire logic hdlcBufEmpty,
  input wire logic hdlcLastByteSetup,
  input wire logic tx_link_underrun,
  input wire logic tx_link_irq,
  input wire logic lineBitReq,
  input wire logic line_clk_out,
  input wire logic pos_pulse_out,
  input wire logic neg_pulse_out,
  input wire logic single_rail_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // data-link pins
  // ---------------------------------------------------------------
  link_clk_cause_a: assert property ($rose(tx_link_clk_out) |-> $past(linkSlot))
    else $error("link clock rose without a slot request");
  link_clk_hold_a: assert property ($rose(tx_link_clk_out) |-> tx_link_clk_out [*8])
    else $error("link clock high phase too short");
  link_sample_a: assert property (linkBitValid |-> $rose(tx_link_clk_out))
    else $error("link bit not taken at the clock rise");
  underrun_cause_a: assert property ($rose(tx_link_underrun) |-> tx_link_irq && $past(hdlcBufEmpty))
    else $error("underrun without empty buffer and pending request");
  link_irq_cause_a: assert property ($rose(tx_link_irq) |->
    $past(hdlcLastByteSetup) || $past(hdlcLastByteSetup, 2) || $past(hdlcLastByteSetup, 3))
    else $error("link interrupt without last byte setup");
  // ---------------------------------------------------------------
  // line pins
  // ---------------------------------------------------------------
  line_update_a: assert property (lineBitReq |-> $past(line_clk_out) != $past(line_clk_out, 2))
    else $error("line outputs updated away from a clock edge");
  single_rail_a: assert property (single_rail_out |-> pos_pulse_out && !neg_pulse_out)
    else $error("single rail pin pairing broken");
  dual_rail_neg_a: assert property (neg_pulse_out |-> !single_rail_out)
    else $error("negative pulse seen in single rail mode");
endmodule // txll_tx_checker

// file: tb/txll_far_end.sv
// model: line clocks and external data-link source facing the block
`timescale 1ns/100ps
module txll_far_end #(
  parameter logic [7:0] PATTERN = 8'hB4
) (
  input  wire logic tx_link_clk_out,
  output logic      line_clk_in,
  output logic      recovered_rx_clk,
  output logic      backplane_tx_clk,
  output logic      tx_link_data_in
);
  logic [2:0] bitIdx = 3'h0;
  // line input runs at eight times the line rate, the others at the line rate
  initial line_clk_in = 1'b0;
  always #40 line_clk_in = ~line_clk_in;
  initial recovered_rx_clk = 1'b0;
  always #320 recovered_rx_clk = ~recovered_rx_clk;
  initial begin
    backplane_tx_clk = 1'b0;
    #137;
    forever #320 backplane_tx_clk = ~backplane_tx_clk;
  end
  // next bit offered after each fall, so it is long settled at the next rise
  // the first fall out of reset is not a frame end, so only count falls after a rise
  logic seenHigh = 1'b0;
  always @(posedge tx_link_clk_out) seenHigh <= 1'b1;
  always @(negedge tx_link_clk_out) if (seenHigh) bitIdx <= bitIdx + 3'h1;
  assign tx_link_data_in = PATTERN[bitIdx];
endmodule // txll_far_end

// file: tb/tb_top.sv
// testbench: self-checking bench for one transmit line block
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] PAT = 8'hB4;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er, line_clk_in, recovered_rx_clk, backplane_tx_clk, tx_link_data_in;
  logic tx_link_clk_out, tx_link_underrun, tx_link_irq, linkBit, linkBitValid, lineBitReq;
  logic hdlcLastByteSetup = 1'b0, hdlcBufEmpty = 1'b0, linkSlot = 1'b0;
  logic framerPos = 1'b0, framerNeg = 1'b0, framerSerial = 1'b0;
  logic line_clk_out, pos_pulse_out, neg_pulse_out, single_rail_out;
  logic [2:0] k = 3'h0;
  int errTotal = 0, numChecks = 0, cyc = 0;

  always #5 ref_clk = ~ref_clk;
  txll_line_tx dut (
    .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .line_clk_in, .recovered_rx_clk, .backplane_tx_clk, .tx_link_data_in, .tx_link_clk_out,
    .tx_link_underrun, .tx_link_irq, .hdlcLastByteSetup, .hdlcBufEmpty, .linkSlot, .framerPos,
    .framerNeg, .framerSerial, .linkBit, .linkBitValid, .lineBitReq, .line_clk_out, .pos_pulse_out,
    .neg_pulse_out, .single_rail_out
  );
  txll_far_end #(.PATTERN(PAT)) far (
    .tx_link_clk_out, .line_clk_in, .recovered_rx_clk, .backplane_tx_clk, .tx_link_data_in
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_req();
    do tick(1); while (lineBitReq !== 1'b1);
  endtask
  task automatic last_byte();
    @(posedge ref_clk);
    hdlcLastByteSetup <= 1'b1;
    @(posedge ref_clk);
    hdlcLastByteSetup <= 1'b0;
    tick(4);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reg_test();
    apb(1'b0, txll_pkg::OFS_CTRL, 32'h0);
    chk(rd, {23'h0, txll_pkg::CTRL_RST});
    apb(1'b0, txll_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, txll_pkg::OFS_STATE, 32'h0);
    chk(rd & 32'h5, 32'h4);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic link_test();
    logic [2:0] m;
    logic en;
    int hi;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      en = (!m[0] | m[1]) & !(m[2] & !m[1]);
      apb(1'b1, txll_pkg::OFS_CTRL, {29'h1, m});
      @(posedge ref_clk);
      linkSlot <= 1'b1;
      @(posedge ref_clk);
      linkSlot <= 1'b0;
      hi = 0;
      #1;
      repeat (40) begin
        if (tx_link_clk_out === 1'b1) hi++;
        tick(1);
      end
      chk(hi, en ? 32 : 0);
      if (en) begin
        chk({31'h0, linkBit}, {31'h0, PAT[k]});
        k++;
      end
    end
  endtask
  task automatic hdlc_test();
    apb(1'b1, txll_pkg::OFS_CTRL, 32'h9);
    apb(1'b1, txll_pkg::OFS_MASK, 32'h3);
    last_byte();
    chk({30'h0, irq, tx_link_irq}, 32'h3);
    @(posedge ref_clk);
    hdlcBufEmpty <= 1'b1;
    tick(4);
    chk({31'h0, tx_link_underrun}, 32'h1);
    @(posedge ref_clk);
    hdlcBufEmpty <= 1'b0;
    apb(1'b1, txll_pkg::OFS_STATUS, 32'h3);
    tick(3);
    chk({29'h0, irq, tx_link_irq, tx_link_underrun}, 32'h0);
    apb(1'b1, txll_pkg::OFS_MASK, 32'h0);
    last_byte();
    chk({30'h0, irq, tx_link_irq}, 32'h1);
    apb(1'b1, txll_pkg::OFS_STATUS, 32'h1);
    apb(1'b1, txll_pkg::OFS_CTRL, 32'h8);
    last_byte();
    chk({31'h0, tx_link_irq}, 32'h0);
  endtask
  task automatic line_case(input logic [8:0] c, input logic p, input logic n, input logic s);
    logic lvl;
    apb(1'b1, txll_pkg::OFS_CTRL, {23'h0, c});
    framerPos <= p;
    framerNeg <= n;
    framerSerial <= s;
    wait_req();
    wait_req();
    chk({31'h0, line_clk_out}, {31'h0, !c[5]});
    chk({29'h0, pos_pulse_out, neg_pulse_out, single_rail_out},
        c[3] ? {29'h0, p, n, 1'b0} : {29'h0, s, 1'b0, s});
    lvl = line_clk_out;
    while (line_clk_out === lvl) tick(1);
    tick(2);
    // return-to-zero applies to the dual-rail pulses only
    chk({30'h0, pos_pulse_out, neg_pulse_out},
        c[3] ? (c[4] ? {30'h0, p, n} : 32'h0) : {30'h0, s, 1'b0});
  endtask
  task automatic clk_src_test();
    int n;
    logic prev;
    for (int src = 0; src < 3; src++) begin
      for (int at = 0; at < 2; at++) begin
        apb(1'b1, txll_pkg::OFS_CTRL, 32'h8 | (src << 6) | (at << 8));
        tick(1000);
        n = 0;
        prev = line_clk_out;
        repeat (1280) begin
          tick(1);
          if (line_clk_out === 1'b1 && prev === 1'b0) n++;
          prev = line_clk_out;
        end
        chk({31'h0, n >= 19 && n <= 21}, 32'h1);
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errTotal++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    reg_test();
    link_test();
    hdlc_test();
    line_case(9'h008, 1'b1, 1'b1, 1'b0);
    line_case(9'h018, 1'b1, 1'b0, 1'b1);
    line_case(9'h038, 1'b0, 1'b1, 1'b1);
    line_case(9'h000, 1'b0, 1'b0, 1'b1);
    line_case(9'h020, 1'b1, 1'b1, 1'b1);
    clk_src_test();
    tally_and_finish();
  end
endmodule // tb_top

bind txll_line_tx txll_tx_checker chk_i (
  .ref_clk, .reset, .linkSlot, .tx_link_clk_out, .linkBitValid, .hdlcBufEmpty, .hdlcLastByteSetup,
  .tx_link_underrun, .tx_link_irq, .lineBitReq, .line_clk_out, .pos_pulse_out, .neg_pulse_out, .single_rail_out
);
